// >>> hw/pclm_app_end.sv
// Application end: runs master bursts over the local port and forwards interrupts
`timescale 1ns/1ps
module pclm_app_end (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Local side
    pclm_local_if.app lcl,
    // Burst request
    input wire logic start_i,
    input wire logic [pclm_pkg::PCLM_AD_W-1:0] addr_i,
    input wire logic [pclm_pkg::PCLM_CBE_W-1:0] cmd_i,
    input wire logic [pclm_pkg::PCLM_CBE_W-1:0] byteen_n_i,
    input wire logic [pclm_pkg::PCLM_LEN_W-1:0] len_i,
    output logic busy_o,
    // Write data
    input wire logic [pclm_pkg::PCLM_AD_W-1:0] wdata_i,
    input wire logic wvalid_i,
    output logic wready_o,
    // Read data
    output logic [pclm_pkg::PCLM_AD_W-1:0] rdata_o,
    output logic rvalid_o,
    // Target and interrupt
    input wire logic irq_i,
    output logic [pclm_pkg::PCLM_NUM_BAR-1:0] tgt_bar_hit_o,
    output logic tgt_rom_hit_o
);
    import pclm_pkg::*;

    pclm_app_state_t state_r;
    logic [PCLM_AD_W-1:0] addr_r;
    logic [PCLM_CBE_W-1:0] cmd_r;
    logic [PCLM_CBE_W-1:0] be_r;
    logic [PCLM_LEN_W-1:0] len_r;
    logic [PCLM_LEN_W-1:0] cnt_r;
    logic last_sent_r;
    logic rvalid_r;
    logic [PCLM_AD_W-1:0] rdata_r;
    logic [PCLM_NUM_BAR-1:0] hit_r;
    logic rom_r;
    logic is_write;
    logic ack;
    logic in_data;
    logic last_now;

    assign is_write = cmd_r[PCLM_CMD_WRITE_BIT];
    assign in_data = (state_r == PCLM_A_DATA);
    assign ack = in_data & ~lcl.mst_local_xfer_ack_n;
    assign last_now = in_data & ~last_sent_r & (cnt_r == len_r - 8'h01);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= PCLM_A_IDLE;
        end else begin
            case (state_r)
                PCLM_A_IDLE: begin
                    if (start_i && len_i != PCLM_LEN_RST) begin
                        state_r <= PCLM_A_ADDR;
                    end
                end
                PCLM_A_ADDR: state_r <= PCLM_A_DATA;
                PCLM_A_DATA: begin
                    if (ack && cnt_r == len_r - 8'h01) begin
                        state_r <= PCLM_A_IDLE;
                    end
                end
                default: state_r <= PCLM_A_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_r <= PCLM_AD_RST;
            cmd_r <= PCLM_CBE_RST;
            be_r <= PCLM_CBE_RST;
            len_r <= PCLM_LEN_RST;
        end else if (state_r == PCLM_A_IDLE && start_i) begin
            addr_r <= addr_i;
            cmd_r <= cmd_i;
            be_r <= byteen_n_i;
            len_r <= len_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= PCLM_LEN_RST;
            last_sent_r <= 1'b0;
        end else if (state_r == PCLM_A_ADDR) begin
            cnt_r <= PCLM_LEN_RST;
            last_sent_r <= 1'b0;
        end else begin
            if (ack) begin
                cnt_r <= cnt_r + 8'h01;
            end
            if (last_now) begin
                last_sent_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= PCLM_AD_RST;
        end else begin
            rvalid_r <= ack & ~is_write;
            if (ack && !is_write) begin
                rdata_r <= lcl.mst_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit_r <= '0;
            rom_r <= 1'b0;
        end else begin
            hit_r <= lcl.bar_hit;
            rom_r <= lcl.rom_hit;
        end
    end

    // Request falls together with address and command
    assign lcl.mst_bus_request_n = ~(state_r == PCLM_A_ADDR);
    assign lcl.mst_addr_wdata_in = (state_r == PCLM_A_ADDR) ? addr_r : wdata_i;
    assign lcl.mst_cmd_byteen_in_n = (state_r == PCLM_A_ADDR) ? cmd_r : be_r;
    assign lcl.mst_final_phase_n = ~last_now;
    // Missing write data stalls the burst instead of sending stale words
    assign lcl.mst_local_stall_n = ~in_data | ~is_write | wvalid_i;
    assign lcl.local_irq_n = ~irq_i;

    assign busy_o = (state_r != PCLM_A_IDLE);
    assign wready_o = ack & is_write;
    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign tgt_bar_hit_o = hit_r;
    assign tgt_rom_hit_o = rom_r;
endmodule : pclm_app_end

// >>> hw/pclm_core_end.sv
// Bus core end: local master port, target claim flags and interrupt forwarding
`timescale 1ns/1ps

// Operation
// - One claim flag per decode window hit
// - Claim flags follow target frame-active timing
// - ROM claim flag, same frame-active timing
// - INTA# asserted while local interrupt low
// - Local logic lowers request to start master
// - Address and command presented on request fall
// - Local logic may pulse final-phase once
// - Final phase drops FRAME#, asserts IRDY#
// - Local stall deasserts IRDY# for waits
// - No acknowledge while local stall asserted
// - No write acknowledge while target TRDY# deasserted
// - Word moves only in acknowledged cycles
// - Write data follows address; else stall
// - Byte enables sampled on first phase only
// - Write acknowledge when word is captured
// - Read acknowledge when word handed over
// - Registered TRDY# copy to local side
// - Frame-active one clock before DEVSEL#
module pclm_core_end (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Local side
    pclm_local_if.core lcl,
    // Arbitration
    output logic pci_req_n_o,
    input wire logic pci_gnt_n_i,
    // Address/data and command lanes
    input wire logic [pclm_pkg::PCLM_AD_W-1:0] pci_ad_i,
    output logic [pclm_pkg::PCLM_AD_W-1:0] pci_ad_o,
    output logic pci_ad_oe_o,
    input wire logic [pclm_pkg::PCLM_CBE_W-1:0] pci_cbe_n_i,
    output logic [pclm_pkg::PCLM_CBE_W-1:0] pci_cbe_n_o,
    output logic pci_cbe_oe_o,
    // Transaction control
    input wire logic pci_frame_n_i,
    output logic pci_frame_n_o,
    output logic pci_frame_oe_o,
    input wire logic pci_irdy_n_i,
    output logic pci_irdy_n_o,
    output logic pci_irdy_oe_o,
    input wire logic pci_trdy_n_i,
    output logic pci_trdy_n_o,
    output logic pci_trdy_oe_o,
    input wire logic pci_devsel_n_i,
    output logic pci_devsel_n_o,
    output logic pci_devsel_oe_o,
    // Open-drain interrupt
    output logic pci_inta_n_o,
    output logic pci_inta_oe_o
);
    import pclm_pkg::*;

    pclm_mst_state_t state_r;
    logic req_d_r;
    logic [PCLM_AD_W-1:0] addr_r;
    logic [PCLM_CBE_W-1:0] cmd_r;
    logic [PCLM_CBE_W-1:0] be_r;
    logic first_r;
    logic last_pend_r;
    logic frame_off_r;
    logic rd_hold_r;
    logic [PCLM_AD_W-1:0] rdata_r;
    logic trdy_reg_r;
    logic frame_d_r;
    logic tgt_active_r;
    logic devsel_r;
    logic [PCLM_NUM_BAR-1:0] hit_r;
    logic rom_r;

    logic req_fall;
    logic is_write;
    logic in_data;
    logic last_seen;
    logic rd_ack;
    logic irdy_assert;
    logic frame_assert;
    logic xfer;
    logic done;
    logic addr_phase;
    logic [PCLM_NUM_BAR-1:0] hit_vec;
    logic rom_match;
    logic tgt_end;

    // Master side
    assign req_fall = req_d_r & ~lcl.mst_bus_request_n;
    assign is_write = cmd_r[PCLM_CMD_WRITE_BIT];
    assign in_data = (state_r == PCLM_M_DATA);
    assign last_seen = last_pend_r | ~lcl.mst_final_phase_n;
    assign rd_ack = ~is_write & rd_hold_r & lcl.mst_local_stall_n;
    // A held read word blocks the next phase so no word is dropped
    assign irdy_assert = in_data & lcl.mst_local_stall_n
                         & (is_write | ~rd_hold_r | rd_ack);
    // FRAME# drops only with IRDY# asserted, so the stall delays it too
    assign frame_assert = (state_r == PCLM_M_ADDR)
                          | (in_data & ~frame_off_r & ~(last_seen & irdy_assert));
    assign xfer = irdy_assert & ~pci_trdy_n_i;
    assign done = xfer & ~frame_assert;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_d_r <= 1'b1;
        end else begin
            req_d_r <= lcl.mst_bus_request_n;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= PCLM_M_IDLE;
        end else begin
            case (state_r)
                PCLM_M_IDLE: begin
                    if (req_fall) begin
                        state_r <= PCLM_M_REQ;
                    end
                end
                PCLM_M_REQ: begin
                    if (!pci_gnt_n_i && pci_frame_n_i && pci_irdy_n_i) begin
                        state_r <= PCLM_M_ADDR;
                    end
                end
                PCLM_M_ADDR: state_r <= PCLM_M_DATA;
                PCLM_M_DATA: begin
                    if (done) begin
                        state_r <= PCLM_M_TURN;
                    end
                end
                PCLM_M_TURN: state_r <= PCLM_M_IDLE;
                default: state_r <= PCLM_M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_r <= PCLM_AD_RST;
            cmd_r <= PCLM_CBE_RST;
        end else if (state_r == PCLM_M_IDLE && req_fall) begin
            addr_r <= lcl.mst_addr_wdata_in;
            cmd_r <= lcl.mst_cmd_byteen_in_n;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            be_r <= PCLM_CBE_RST;
            first_r <= 1'b0;
        end else if (state_r == PCLM_M_ADDR) begin
            first_r <= 1'b1;
        end else if (in_data && first_r && xfer) begin
            be_r <= lcl.mst_cmd_byteen_in_n;
            first_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_pend_r <= 1'b0;
            frame_off_r <= 1'b0;
        end else if (state_r == PCLM_M_IDLE) begin
            last_pend_r <= 1'b0;
            frame_off_r <= 1'b0;
        end else begin
            if (!lcl.mst_final_phase_n) begin
                last_pend_r <= 1'b1;
            end
            if (in_data && !frame_assert) begin
                frame_off_r <= 1'b1;
            end
        end
    end

    // One-word read holding stage; a new word wins over the hand-off
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_hold_r <= 1'b0;
            rdata_r <= PCLM_AD_RST;
        end else if (xfer && !is_write) begin
            rd_hold_r <= 1'b1;
            rdata_r <= pci_ad_i;
        end else if (rd_ack) begin
            rd_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trdy_reg_r <= 1'b1;
        end else begin
            trdy_reg_r <= pci_trdy_n_i;
        end
    end

    // Write acknowledge is the capture cycle itself, so TRDY# gates it
    assign lcl.mst_local_xfer_ack_n = is_write ? ~xfer : ~rd_ack;
    assign lcl.mst_rdata = rdata_r;
    assign lcl.trdy_reg_n = trdy_reg_r;

    assign pci_req_n_o = ~(state_r == PCLM_M_REQ);
    assign pci_ad_oe_o = (state_r == PCLM_M_ADDR) | (in_data & is_write);
    assign pci_ad_o = (state_r == PCLM_M_ADDR) ? addr_r : lcl.mst_addr_wdata_in;
    assign pci_cbe_oe_o = (state_r == PCLM_M_ADDR) | in_data;
    assign pci_cbe_n_o = (state_r == PCLM_M_ADDR) ? cmd_r
                         : (first_r ? lcl.mst_cmd_byteen_in_n : be_r);
    assign pci_frame_oe_o = (state_r == PCLM_M_ADDR) | in_data;
    assign pci_frame_n_o = ~frame_assert;
    assign pci_irdy_oe_o = in_data | (state_r == PCLM_M_TURN);
    assign pci_irdy_n_o = ~irdy_assert;

    // Target claim decode
    assign addr_phase = frame_d_r & ~pci_frame_n_i & (state_r != PCLM_M_ADDR);
    assign rom_match = (pci_ad_i & PCLM_ROM_MASK) == PCLM_ROM_BASE;
    assign tgt_end = devsel_r & pci_frame_n_i & ~pci_irdy_n_i;

    genvar g;
    generate
        for (g = 0; g < PCLM_NUM_BAR; g++) begin : g_bar
            assign hit_vec[g] = (pci_ad_i & PCLM_BAR_MASK[g]) == PCLM_BAR_BASE[g];
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frame_d_r <= 1'b1;
        end else begin
            frame_d_r <= pci_frame_n_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tgt_active_r <= 1'b0;
            hit_r <= '0;
            rom_r <= 1'b0;
        end else if (tgt_end) begin
            tgt_active_r <= 1'b0;
            hit_r <= '0;
            rom_r <= 1'b0;
        end else if (addr_phase && !tgt_active_r && (|hit_vec || rom_match)) begin
            tgt_active_r <= 1'b1;
            hit_r <= hit_vec;
            rom_r <= rom_match & ~|hit_vec;
        end
    end

    // DEVSEL# trails frame-active by one clock; this end never retries
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            devsel_r <= 1'b0;
        end else begin
            devsel_r <= tgt_active_r & ~tgt_end;
        end
    end

    assign lcl.tgt_frame_active_n = ~tgt_active_r;
    assign lcl.bar_hit = hit_r;
    assign lcl.rom_hit = rom_r;
    assign pci_devsel_oe_o = devsel_r;
    assign pci_devsel_n_o = ~devsel_r;
    assign pci_trdy_oe_o = devsel_r;
    assign pci_trdy_n_o = ~devsel_r;

    // Open drain: pull low only, never drive high
    assign pci_inta_n_o = 1'b0;
    assign pci_inta_oe_o = ~lcl.local_irq_n;
endmodule : pclm_core_end

// >>> shared/pclm_local_if.sv
// Local-side interface between the bus core and the application logic
`timescale 1ns/1ps
interface pclm_local_if;
    import pclm_pkg::*;
    logic mst_bus_request_n;
    logic mst_final_phase_n;
    logic mst_local_stall_n;
    logic [PCLM_AD_W-1:0] mst_addr_wdata_in;
    logic [PCLM_CBE_W-1:0] mst_cmd_byteen_in_n;
    logic mst_local_xfer_ack_n;
    logic [PCLM_AD_W-1:0] mst_rdata;
    logic trdy_reg_n;
    logic tgt_frame_active_n;
    logic [PCLM_NUM_BAR-1:0] bar_hit;
    logic rom_hit;
    logic local_irq_n;

    modport core (
        input mst_bus_request_n, mst_final_phase_n, mst_local_stall_n,
        input mst_addr_wdata_in, mst_cmd_byteen_in_n, local_irq_n,
        output mst_local_xfer_ack_n, mst_rdata, trdy_reg_n,
        output tgt_frame_active_n, bar_hit, rom_hit
    );
    modport app (
        output mst_bus_request_n, mst_final_phase_n, mst_local_stall_n,
        output mst_addr_wdata_in, mst_cmd_byteen_in_n, local_irq_n,
        input mst_local_xfer_ack_n, mst_rdata, trdy_reg_n,
        input tgt_frame_active_n, bar_hit, rom_hit
    );
endinterface : pclm_local_if

// >>> shared/pclm_pkg.sv
// Shared constants and types for the local master port and its application end
package pclm_pkg;
    localparam int PCLM_AD_W = 32;
    localparam int PCLM_CBE_W = 4;
    localparam int PCLM_NUM_BAR = 6;
    localparam int PCLM_LEN_W = 8;

    // Decode windows: an address hits when (ad & mask) == base
    localparam logic [PCLM_NUM_BAR-1:0][PCLM_AD_W-1:0] PCLM_BAR_BASE = {
        32'h5000_0000, 32'h4000_0000, 32'h3000_0000,
        32'h2000_0000, 32'h1000_0000, 32'h0000_0000
    };
    localparam logic [PCLM_NUM_BAR-1:0][PCLM_AD_W-1:0] PCLM_BAR_MASK = {
        32'hffff_0000, 32'hffff_0000, 32'hffff_0000,
        32'hffff_0000, 32'hffff_0000, 32'hffff_0000
    };
    localparam logic [PCLM_AD_W-1:0] PCLM_ROM_BASE = 32'h6000_0000;
    localparam logic [PCLM_AD_W-1:0] PCLM_ROM_MASK = 32'hfff0_0000;

    // Command encodings, as on C/BE#
    localparam logic [PCLM_CBE_W-1:0] PCLM_CMD_IO_READ = 4'h2;
    localparam logic [PCLM_CBE_W-1:0] PCLM_CMD_IO_WRITE = 4'h3;
    localparam logic [PCLM_CBE_W-1:0] PCLM_CMD_MEM_READ = 4'h6;
    localparam logic [PCLM_CBE_W-1:0] PCLM_CMD_MEM_WRITE = 4'h7;
    localparam int PCLM_CMD_WRITE_BIT = 0;

    // Reset values
    localparam logic [PCLM_AD_W-1:0] PCLM_AD_RST = 32'h0000_0000;
    localparam logic [PCLM_CBE_W-1:0] PCLM_CBE_RST = 4'hf;
    localparam logic [PCLM_LEN_W-1:0] PCLM_LEN_RST = 8'h00;

    typedef enum logic [2:0] {
        PCLM_M_IDLE,
        PCLM_M_REQ,
        PCLM_M_ADDR,
        PCLM_M_DATA,
        PCLM_M_TURN
    } pclm_mst_state_t;

    typedef enum logic [1:0] {
        PCLM_A_IDLE,
        PCLM_A_ADDR,
        PCLM_A_DATA
    } pclm_app_state_t;
endpackage : pclm_pkg

// >>> verification/pclm_props.sv
// Concurrent checks on the local port between the two ends
`timescale 1ns/1ps
module pclm_props (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Local port
    input wire logic mst_bus_request_n,
    input wire logic mst_final_phase_n,
    input wire logic mst_local_stall_n,
    input wire logic mst_local_xfer_ack_n,
    input wire logic tgt_frame_active_n,
    input wire logic [pclm_pkg::PCLM_NUM_BAR-1:0] bar_hit,
    input wire logic rom_hit
);
    import pclm_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    AST_ACK_STALL: assert property (!mst_local_stall_n |-> mst_local_xfer_ack_n)
        else $error("ack while stalled");
    AST_ACK_REQ: assert property (!mst_local_xfer_ack_n |-> mst_bus_request_n)
        else $error("ack in address cycle");
    AST_LAST_ONE: assert property (!mst_final_phase_n |=> mst_final_phase_n)
        else $error("final phase longer than one clock");
    AST_HIT_IDLE: assert property (tgt_frame_active_n |-> bar_hit == '0 && !rom_hit)
        else $error("claim flag outside frame active");
    AST_HIT_SET: assert property ($fell(tgt_frame_active_n) |-> $onehot({rom_hit, bar_hit}))
        else $error("no claim flag with frame active");
    AST_HIT_HOLD: assert property (!tgt_frame_active_n && $past(tgt_frame_active_n) == 1'b0
        |-> $stable({rom_hit, bar_hit}))
        else $error("claim flags moved within access");
    AST_ACTIVE_MIN: assert property ($fell(tgt_frame_active_n) |=> !tgt_frame_active_n)
        else $error("frame active too short");
    AST_HIT_ONE: assert property ($onehot0({rom_hit, bar_hit}))
        else $error("several claim flags");

    cover property (!mst_local_xfer_ack_n && !mst_final_phase_n);
    cover property ($fell(tgt_frame_active_n) && rom_hit);
    cover property (!mst_local_stall_n);
endmodule : pclm_props

// >>> verification/tb_pci_core_local_master_port.sv
// Bench joining core end and application end, acting as PCI arbiter, target and master
`timescale 1ns/1ps
module tb_pci_core_local_master_port;
    import pclm_pkg::*;
    logic clk_sys_i, arst_n_i = 1'b0, pci_gnt_n_i = 1'b1, start_i = 1'b0, wvalid_i = 1'b0;
    logic irq_i = 1'b0, tb_frame_n = 1'b1, tb_irdy_n = 1'b1, tb_trdy_n = 1'b1;
    logic tb_devsel_n = 1'b1, tgt_mode = 1'b0, cur_w = 1'b0;
    logic busy_o, wready_o, rvalid_o, pci_req_n_o, pci_ad_oe_o, pci_cbe_oe_o, pci_frame_n_o;
    logic pci_frame_oe_o, pci_irdy_n_o, pci_irdy_oe_o, pci_trdy_n_o, pci_trdy_oe_o;
    logic pci_devsel_n_o, pci_devsel_oe_o, pci_inta_n_o, pci_inta_oe_o, tgt_rom_hit_o;
    logic pci_frame_n_i, pci_irdy_n_i, pci_trdy_n_i, pci_devsel_n_i, trdy_q, dv_q, fa_q;
    logic [31:0] tb_ad = 32'h0, addr_i = 32'h0, wdata_i = 32'h0, rs = 32'h30;
    logic [31:0] pci_ad_i, pci_ad_o, rdata_o;
    logic [3:0] cmd_i = 4'h0, byteen_n_i = 4'hf, pci_cbe_n_i, pci_cbe_n_o;
    logic [7:0] len_i = 8'h0;
    logic [5:0] tgt_bar_hit_o;
    logic [6:0] seen, seen_o;
    logic [31:0] wq[$], rq[$];
    int n_fail = 0, n_checks = 0, n_wx = 0, n_rv = 0;

    pclm_local_if lcl();
    // Resolve shared PCI lines from the core end's enables; the bench values drive them otherwise
    assign pci_frame_n_i = pci_frame_oe_o ? pci_frame_n_o : tb_frame_n;
    assign pci_irdy_n_i = pci_irdy_oe_o ? pci_irdy_n_o : tb_irdy_n;
    assign pci_trdy_n_i = pci_trdy_oe_o ? pci_trdy_n_o : tb_trdy_n;
    assign pci_devsel_n_i = pci_devsel_oe_o ? pci_devsel_n_o : tb_devsel_n;
    assign pci_ad_i = pci_ad_oe_o ? pci_ad_o : tb_ad;
    assign pci_cbe_n_i = pci_cbe_oe_o ? pci_cbe_n_o : PCLM_CMD_MEM_READ;

    pclm_core_end pclm_core_end_i (.clk_sys_i, .arst_n_i, .lcl, .pci_req_n_o, .pci_gnt_n_i,
        .pci_ad_i, .pci_ad_o, .pci_ad_oe_o, .pci_cbe_n_i, .pci_cbe_n_o, .pci_cbe_oe_o,
        .pci_frame_n_i, .pci_frame_n_o, .pci_frame_oe_o, .pci_irdy_n_i, .pci_irdy_n_o,
        .pci_irdy_oe_o, .pci_trdy_n_i, .pci_trdy_n_o, .pci_trdy_oe_o, .pci_devsel_n_i,
        .pci_devsel_n_o, .pci_devsel_oe_o, .pci_inta_n_o, .pci_inta_oe_o);
    pclm_app_end pclm_app_end_i (.clk_sys_i, .arst_n_i, .lcl, .start_i, .addr_i, .cmd_i,
        .byteen_n_i, .len_i, .busy_o, .wdata_i, .wvalid_i, .wready_o, .rdata_o, .rvalid_o,
        .irq_i, .tgt_bar_hit_o, .tgt_rom_hit_o);
    pclm_props pclm_props_i (.clk_sys_i, .arst_n_i,
        .mst_bus_request_n(lcl.mst_bus_request_n), .mst_final_phase_n(lcl.mst_final_phase_n),
        .mst_local_stall_n(lcl.mst_local_stall_n),
        .mst_local_xfer_ack_n(lcl.mst_local_xfer_ack_n),
        .tgt_frame_active_n(lcl.tgt_frame_active_n), .bar_hit(lcl.bar_hit),
        .rom_hit(lcl.rom_hit));

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    function automatic logic [6:0] exp_hit(input logic [31:0] a);
        for (int i = 0; i < PCLM_NUM_BAR; i++) begin
            if ((a & PCLM_BAR_MASK[i]) == PCLM_BAR_BASE[i]) return 7'(1 << i);
        end
        return ((a & PCLM_ROM_MASK) == PCLM_ROM_BASE) ? 7'h40 : 7'h00;
    endfunction : exp_hit

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // Arbiter, target for master bursts, random write data
    always @(posedge clk_sys_i) begin
        pci_gnt_n_i <= pci_req_n_o;
        wdata_i <= rnd();
        wvalid_i <= rs[1] | rs[2];
        tb_devsel_n <= !(pci_frame_oe_o || pci_irdy_oe_o);
        tb_trdy_n <= !(pci_frame_oe_o || pci_irdy_oe_o) || rs[3];
        if (!tgt_mode) tb_ad <= rnd();
    end

    always @(posedge clk_sys_i) begin
        trdy_q <= pci_trdy_n_i;
        dv_q <= pci_devsel_oe_o && !pci_devsel_n_o;
        fa_q <= lcl.tgt_frame_active_n;
        if (arst_n_i) chk(32'(lcl.trdy_reg_n), 32'(trdy_q));
        if (pci_devsel_oe_o && !pci_devsel_n_o && !dv_q) chk(32'(fa_q), 32'h0);
        if (!lcl.tgt_frame_active_n) seen <= seen | {lcl.rom_hit, lcl.bar_hit};
        seen_o <= seen_o | {tgt_rom_hit_o, tgt_bar_hit_o};
        if (wready_o) wq.push_back(wdata_i);
        if (rvalid_o) begin
            n_rv++;
            chk(rdata_o, rq.size() > 0 ? rq.pop_front() : ~rdata_o);
        end
        if (pci_irdy_oe_o && !pci_irdy_n_o && !pci_trdy_n_i && !pci_devsel_n_i) begin
            n_wx++;
            if (!cur_w) rq.push_back(pci_ad_i);
            else begin
                chk(pci_ad_o, wq.size() > 0 ? wq.pop_front() : ~pci_ad_o);
                chk(32'(pci_cbe_n_o), 32'(byteen_n_i));
                if (n_wx == len_i) chk(32'(pci_frame_n_o), 32'h1);
            end
        end
    end

    task automatic irq(input logic v);
        @(posedge clk_sys_i) irq_i <= v;
        repeat (3) @(posedge clk_sys_i);
        chk(32'(pci_inta_oe_o), 32'(v));
        chk(32'(pci_inta_n_o), 32'h0);
        $display("interrupt %0d done", v);
    endtask : irq

    task automatic tgt(input logic [31:0] a);
        int i;
        @(negedge clk_sys_i);
        tgt_mode = 1'b1;
        seen = '0;
        seen_o = '0;
        @(posedge clk_sys_i);
        tb_ad <= a;
        tb_frame_n <= 1'b0;
        @(posedge clk_sys_i);
        tb_frame_n <= 1'b1;
        tb_irdy_n <= 1'b0;
        // A miss never answers, so the wait is bounded
        for (i = 0; i < 6 && !(pci_devsel_oe_o && !pci_devsel_n_o); i++) @(posedge clk_sys_i);
        tb_irdy_n <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk(32'(seen), 32'(exp_hit(a)));
        chk(32'(seen_o), 32'(exp_hit(a)));
        chk(32'(lcl.tgt_frame_active_n), 32'h1);
        @(negedge clk_sys_i) tgt_mode = 1'b0;
        $display("target %h done", a);
    endtask : tgt

    task automatic mst(input logic w, input logic [7:0] len);
        int i;
        @(posedge clk_sys_i);
        void'(rnd());
        cur_w = w;
        n_wx = 0;
        n_rv = 0;
        wq.delete();
        rq.delete();
        // Addresses kept outside every window so the core never claims itself
        addr_i <= {16'h8000, rs[15:2], 2'h0};
        cmd_i <= w ? (rs[20] ? PCLM_CMD_IO_WRITE : PCLM_CMD_MEM_WRITE)
                   : (rs[20] ? PCLM_CMD_IO_READ : PCLM_CMD_MEM_READ);
        byteen_n_i <= rs[19:16];
        len_i <= len;
        start_i <= 1'b1;
        @(posedge clk_sys_i) start_i <= 1'b0;
        @(posedge clk_sys_i);
        // A write burst may still be closing on the bus after the app end is done
        for (i = 0; i < 2000 && (busy_o !== 1'b0 || pci_irdy_oe_o !== 1'b0); i++) begin
            @(posedge clk_sys_i);
        end
        repeat (4) @(posedge clk_sys_i);
        if (i == 2000) n_fail++;
        chk(32'(w ? n_wx : n_rv), 32'(len));
        chk(32'(w ? wq.size() : 0), 32'h0);
        $display("master %0d len %0d done", w, len);
    endtask : mst

    initial begin
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        irq(1'b1);
        irq(1'b0);
        for (int k = 0; k < 8; k++) begin
            void'(rnd());
            tgt(k < 6 ? PCLM_BAR_BASE[k] | (rs & 32'hfffc) : k == 6 ?
                PCLM_ROM_BASE | (rs & 32'hffffc) : 32'h9000_0000);
        end
        mst(1'b1, 8'h01);
        mst(1'b0, 8'h01);
        for (int k = 0; k < 24; k++) begin
            void'(rnd());
            mst(rs[0], 8'(rs[4:1]) + 8'h01);
        end
        mst(1'b1, 8'hff);
        tally_and_finish();
    end

    initial begin
        repeat (30000) @(posedge clk_sys_i);
        n_fail++;
        $display("unexpected timeout at %0t", $time);
        tally_and_finish();
    end
endmodule : tb_pci_core_local_master_port
